// ===== hw/swd_top.sv
`timescale 1ns/100ps
`include "swd_consts.svh"

// Contract
// - decode 000..100 as low/high/fall/rise/both
// - edge status: 01 rise, 10 fall, 11 both
// - edge status meaningful only in both mode
// - clearing a request also clears edge status
// - one enable bit per channel, 1 enables
module swd_top #(
  parameter int NCH = 4
) (
  // clock, reset, enable
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            ce,
  // register bus
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // external wake pins, one per channel, channels 0..NCH-1
  input  wire logic [NCH-1:0]  wake_pin,
  // wake and interrupt outputs
  output logic                 wake_req,
  output logic                 irq
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_m;
  logic rst_q;

  // asynchronous assert, two-flop release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_q <= rst_m;
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [NCH-1:0][2:0] mode_q;
  logic [NCH-1:0][1:0] stat_q;
  logic [NCH-1:0]      en_q;
  logic [NCH-1:0]      pend_q;
  logic [NCH-1:0]      mask_q;
  logic [NCH-1:0]      hit;
  logic [NCH-1:0]      rise;
  logic [NCH-1:0]      fall;
  logic [NCH-1:0]      clr;
  logic                acc;
  logic                setup;
  logic                wr;
  logic                mapped;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte lane of channel k within a register word
  function automatic logic [7:0] swd_lane(input logic [31:0] w, input int k);
    swd_lane = w[k*`SWD_CH_W +: `SWD_CH_W];
  endfunction

  // mode field of channel k; a call result cannot be sliced directly
  function automatic logic [2:0] swd_mode_of(input logic [31:0] w, input int k);
    logic [7:0] lane;
    lane        = swd_lane(w, k);
    swd_mode_of = lane[`SWD_MODE_LSB +: 3];
  endfunction

  // enable bit of channel k
  function automatic logic swd_en_of(input logic [31:0] w, input int k);
    logic [7:0] lane;
    lane      = swd_lane(w, k);
    swd_en_of = lane[`SWD_EN_BIT];
  endfunction

  // address decode, used for writes and for the error answer
  function automatic logic swd_hit_addr(input logic [7:0] a);
    swd_hit_addr = (a == `SWD_OFF_MODE) || (a == `SWD_OFF_CLR) || (a == `SWD_OFF_MASK);
  endfunction

  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  assign setup  = psel & ~penable;
  assign acc    = psel & penable;
  assign wr     = acc & pwrite & ce & swd_hit_addr(paddr);
  assign mapped = swd_hit_addr(paddr);

  // zero wait states; the error flag marks unmapped addresses
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // ----------------------------------------
  // per-channel detectors
  // ----------------------------------------
  for (genvar k = 0; k < NCH; k++) begin : g_ch
    swd_edge_det u_det (
      .mclk (mclk),
      .rst_n(rst_q),
      .ce   (ce),
      .pin  (wake_pin[k]),
      .mode (mode_q[k]),
      .en   (en_q[k]),
      .hit  (hit[k]),
      .rise (rise[k]),
      .fall (fall[k])
    );
  end

  // ----------------------------------------
  // mode and enable fields
  // ----------------------------------------
  // a prohibited mode is stored as written; the detector ignores it
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      for (int k = 0; k < NCH; k++) begin
        mode_q[k] <= `SWD_MODE_RST;
        en_q[k]   <= 1'b0;
      end
    end else if (wr && paddr == `SWD_OFF_MODE) begin
      for (int k = 0; k < NCH; k++) begin
        mode_q[k] <= swd_mode_of(pwdata, k);
        en_q[k]   <= swd_en_of(pwdata, k);
      end
    end
  end

  // ----------------------------------------
  // interrupt mask
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      mask_q <= '0;
    end else if (wr && paddr == `SWD_OFF_MASK) begin
      mask_q <= pwdata[NCH-1:0];
    end
  end

  // ----------------------------------------
  // pending requests and edge status
  // ----------------------------------------
  // write one to the clear register drops the matching channel
  assign clr = (wr && paddr == `SWD_OFF_CLR) ? pwdata[NCH-1:0] : '0;

  // a new request in the clearing cycle survives the clear
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      pend_q <= '0;
    end else if (ce) begin
      pend_q <= (pend_q & ~clr) | hit;
    end
  end

  // edges accumulate, so rise then fall reads as both
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      stat_q <= '0;
    end else if (ce) begin
      for (int k = 0; k < NCH; k++) begin
        if (mode_q[k] == swd_pkg::SWD_BOTH && en_q[k]) begin
          stat_q[k] <= (clr[k] ? `SWD_ST_NONE : stat_q[k])
                       | {fall[k], rise[k]};
        end else if (clr[k]) begin
          stat_q[k] <= `SWD_ST_NONE;
        end
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wake_req = |pend_q;
  assign irq      = |(pend_q & mask_q);

  // ----------------------------------------
  // read data, loaded in the setup cycle
  // ----------------------------------------
  // reserved bits of every lane read as zero
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      prdata <= '0;
    end else if (ce && setup && !pwrite) begin
      prdata <= '0;
      case (paddr)
        `SWD_OFF_MODE: begin
          for (int k = 0; k < NCH; k++) begin
            prdata[k*`SWD_CH_W +: `SWD_CH_W] <= swd_pkg::swd_chan_t'{
              rsv_hi:             1'b0,
              detect_mode_sel:    mode_q[k],
              detected_edge_stat: stat_q[k],
              rsv_lo:             1'b0,
              wake_chan_en:       en_q[k]};
          end
        end
        `SWD_OFF_CLR: begin
          prdata[NCH-1:0] <= pend_q;
        end
        `SWD_OFF_MASK: begin
          prdata[NCH-1:0] <= mask_q;
        end
        default: begin
          prdata <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_reset_vals;
    @(posedge mclk) disable iff (!rst_n)
      $rose(rst_q) |-> (en_q == '0) && (stat_q == '0) && (mode_q[0] == 3'h2)
        && (mode_q[NCH-1] == 3'h2);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_mode_wr;
    @(posedge mclk) disable iff (!rst_q)
      (wr && paddr == 8'h00) |=> (mode_q[0] == $past(pwdata[6:4]))
        && (mode_q[1] == $past(pwdata[14:12]));
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode field not written");

  property p_en_wr;
    @(posedge mclk) disable iff (!rst_q)
      (wr && paddr == 8'h00) |=> (en_q[0] == $past(pwdata[0]))
        && (en_q[1] == $past(pwdata[8]));
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable bit not written");

  property p_dis_quiet;
    @(posedge mclk) disable iff (!rst_q)
      (!en_q[0] && !clr[0] && !pend_q[0]) |=> !pend_q[0];
  endproperty
  a_dis_quiet: assert property (p_dis_quiet) else $error("disabled channel raised request");

  property p_stat_rise;
    @(posedge mclk) disable iff (!rst_q)
      (ce && rise[0] && en_q[0] && mode_q[0] == 3'h4) |=> stat_q[0][0];
  endproperty
  a_stat_rise: assert property (p_stat_rise) else $error("rise not recorded");

  property p_stat_fall;
    @(posedge mclk) disable iff (!rst_q)
      (ce && fall[0] && en_q[0] && mode_q[0] == 3'h4) |=> stat_q[0][1] && pend_q[0];
  endproperty
  a_stat_fall: assert property (p_stat_fall) else $error("fall not recorded");

  property p_stat_other;
    @(posedge mclk) disable iff (!rst_q)
      (mode_q[0] != 3'h4 && stat_q[0] == 2'h0) |=> stat_q[0] == 2'h0;
  endproperty
  a_stat_other: assert property (p_stat_other) else $error("status set outside both mode");

  property p_clr_stat;
    @(posedge mclk) disable iff (!rst_q)
      (clr[0] && !rise[0] && !fall[0] && !hit[0]) |=> stat_q[0] == 2'h0 && !pend_q[0];
  endproperty
  a_clr_stat: assert property (p_clr_stat) else $error("clear left status set");

  property p_rsv_zero;
    @(posedge mclk) disable iff (!rst_q)
      (ce && setup && !pwrite && paddr == 8'h00) |=> (prdata & 32'h82828282) == 32'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");

  property p_irq;
    @(posedge mclk) disable iff (!rst_q)
      (ce && hit[0] && mask_q[0] && !(wr && paddr == 8'h08)) |=> irq && wake_req;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked request gave no interrupt");

endmodule

// ===== shared/swd_consts.svh
`ifndef SWD_CONSTS_SVH
`define SWD_CONSTS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SWD_OFF_MODE   8'h00
`define SWD_OFF_CLR    8'h04
`define SWD_OFF_MASK   8'h08

// ----------------------------------------
// per-channel field layout, one byte each
// ----------------------------------------
`define SWD_CH_W       8
`define SWD_MODE_LSB   4
`define SWD_STAT_LSB   2
`define SWD_EN_BIT     0
`define SWD_RSV_MASK   32'h82828282

// ----------------------------------------
// reset values and status codes
// ----------------------------------------
`define SWD_MODE_RST   3'h2
`define SWD_ST_NONE    2'h0
`define SWD_ST_RISE    2'h1
`define SWD_ST_FALL    2'h2
`define SWD_ST_BOTH    2'h3

`endif

// ===== shared/swd_pkg.sv
package swd_pkg;

  // detection mode encodings, 101..111 are not to be written
  typedef enum logic [2:0] {
    SWD_LOW  = 3'h0,
    SWD_HIGH = 3'h1,
    SWD_FALL = 3'h2,
    SWD_RISE = 3'h3,
    SWD_BOTH = 3'h4
  } swd_mode_t;

  // one channel's byte of the mode control register
  typedef struct packed {
    logic       rsv_hi;
    logic [2:0] detect_mode_sel;
    logic [1:0] detected_edge_stat;
    logic       rsv_lo;
    logic       wake_chan_en;
  } swd_chan_t;

endpackage

// ===== hw/swd_edge_det.sv
`timescale 1ns/100ps
`include "swd_consts.svh"

module swd_edge_det (
  // clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // pin and channel setup
  input  wire logic       pin,
  input  wire logic [2:0] mode,
  input  wire logic       en,
  // detection results
  output logic            hit,
  output logic            rise,
  output logic            fall
);

  // ----------------------------------------
  // pin synchroniser and agreement filter
  // ----------------------------------------
  logic s1;
  logic s2;
  logic s3;
  logic filt;
  logic agree;

  // three flops; only s2 reads s1
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign agree = (s2 == s3);

  // accepted level moves only when the last two stages agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filt <= 1'b1;
    end else if (ce && agree) begin
      filt <= s3;
    end
  end

  // ----------------------------------------
  // edge and level decode
  // ----------------------------------------
  assign rise = ce & agree & s3 & ~filt;
  assign fall = ce & agree & ~s3 & filt;

  // prohibited encodings detect nothing
  always_comb begin
    case (mode)
      swd_pkg::SWD_LOW:  hit = ~filt;
      swd_pkg::SWD_HIGH: hit = filt;
      swd_pkg::SWD_FALL: hit = fall;
      swd_pkg::SWD_RISE: hit = rise;
      swd_pkg::SWD_BOTH: hit = rise | fall;
      default:           hit = 1'b0;
    endcase
    hit = hit & en & ce;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_filt_agree;
    @(posedge mclk) disable iff (!rst_n)
      $changed(filt) |-> $past(agree) && $past(ce);
  endproperty
  a_filt_agree: assert property (p_filt_agree) else $error("level moved without agreement");

  property p_both_hit;
    @(posedge mclk) disable iff (!rst_n)
      (mode == swd_pkg::SWD_BOTH && en && (rise || fall)) |-> hit;
  endproperty
  a_both_hit: assert property (p_both_hit) else $error("both-edge mode missed an edge");

endmodule

// ===== tb/swd_pin_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// external wake pin source
// ----------------------------------------
module swd_pin_model (
  // clock of the bench
  input  wire logic       mclk,
  // levels asked for by the bench
  input  wire logic [3:0] drive,
  // pins toward the block
  output logic      [3:0] wake_pin
);
  // pins follow the request on the falling edge, off the block's sampling edge;
  // the bench idles the request high, as the block's sync flops assume
  always @(negedge mclk) wake_pin <= drive;
endmodule

// ===== tb/standby_wake_detect_cfg_bench.sv
`timescale 1ns/100ps

module standby_wake_detect_cfg_bench;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        wake_req;
  logic        irq;
  logic        err;
  logic        ce = 1'b1;
  logic [3:0]  drive = 4'hF;
  logic [3:0]  wake_pin;
  int          mismatches = 0;
  int          num_checks = 0;
  integer      seed = 32'h1b4928fd;
  int          mode_m [4];
  int          en_m [4];
  int          stat_m [4];
  int          pend_m;
  int          mask_m;

  always #20 mclk = ~mclk;

  swd_top #(.NCH(4)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_pin(wake_pin), .wake_req(wake_req), .irq(irq)
  );

  swd_pin_model pins_u (.mclk(mclk), .drive(drive), .wake_pin(wake_pin));

  // ----------------------------------------
  // model of the mode register and checks
  // ----------------------------------------
  function automatic logic [31:0] exp_mode();
    logic [31:0] v;
    v = 32'h0;
    for (int k = 0; k < 4; k++) begin
      v[8*k +: 8] = {1'b0, mode_m[k][2:0], stat_m[k][1:0], 1'b0, en_m[k][0]};
    end
    return v;
  endfunction

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t register read %h, model %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t output bit %b, model %b", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_reg(rd, exp);
    chk_bit(err, 1'b0);
  endtask

  task automatic pin_set(input int k, input logic v);
    @(posedge mclk);
    drive[k] <= v;
    repeat (8) @(posedge mclk);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (int k = 0; k < 4; k++) begin
      mode_m[k] = 2;
      en_m[k] = 0;
      stat_m[k] = 0;
    end
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd_chk(8'h00, exp_mode());
    rd_chk(8'h04, 32'h0);
    chk_bit(irq, 1'b0);
    // random legal modes; status and reserved bits written must not stick
    for (int k = 0; k < 4; k++) mode_m[k] = $unsigned($random(seed)) % 5;
    apb(1'b1, 8'h00, exp_mode() | ($random(seed) & 32'h8E8E8E8E));
    rd_chk(8'h00, exp_mode());
    mask_m = 4'hB;
    apb(1'b1, 8'h08, mask_m);
    rd_chk(8'h08, mask_m);
    // every mode once, low pulse on one channel each
    for (int m = 0; m < 5; m++) begin
      int k;
      k = m % 4;
      mode_m[k] = m;
      apb(1'b1, 8'h00, exp_mode());
      en_m[k] = 1;
      apb(1'b1, 8'h00, exp_mode());
      pin_set(k, 1'b0);
      pend_m = (m != 3) ? (1 << k) : 0;
      stat_m[k] = (m == 4) ? 2 : 0;
      rd_chk(8'h04, pend_m);
      rd_chk(8'h00, exp_mode());
      chk_bit(irq, |(pend_m & mask_m));
      chk_bit(wake_req, pend_m != 0);
      pin_set(k, 1'b1);
      pend_m = 1 << k;
      stat_m[k] = (m == 4) ? 3 : 0;
      rd_chk(8'h04, pend_m);
      rd_chk(8'h00, exp_mode());
      en_m[k] = 0;
      apb(1'b1, 8'h00, exp_mode());
      apb(1'b1, 8'h04, 32'h1 << k);
      stat_m[k] = 0;
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h00, exp_mode());
      chk_bit(irq, 1'b0);
    end
    // disabled channel ignores a falling edge
    mode_m[3] = 2;
    apb(1'b1, 8'h00, exp_mode());
    pin_set(3, 1'b0);
    rd_chk(8'h04, 32'h0);
    pin_set(3, 1'b1);
    // clock enable low: a write is ignored and the mask keeps its value
    @(posedge mclk);
    ce <= 1'b0;
    apb(1'b1, 8'h08, 32'h0);
    @(posedge mclk);
    ce <= 1'b1;
    rd_chk(8'h08, mask_m);
    // unmapped address reads zero with an error response
    apb(1'b0, 8'h10, 32'h0);
    chk_reg(rd, 32'h0);
    chk_bit(err, 1'b1);
    report_and_stop();
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #(40 * 20000);
    mismatches++;
    report_and_stop();
  end
endmodule
